//--- common/bca_pkg.sv
/*
  Shared constants, state encoding and subaddress map for the burst CDR control block.
  Assumes a single 50 MHz system clock and the sampled I2C and link pins behind it.
*/
package bca_pkg;
  // ======================================================
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int ACQ_TIME_MS = 10;
  localparam int ACQ_CYCLES = (CLK_HZ / 1000) * ACQ_TIME_MS;
  localparam int PRE_UI = 12;

  // ======================================================
  // Bus address and framing
  localparam logic [4:0] ADDR_HI_BITS = 5'h10;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ======================================================
  // Subaddresses and register indices
  localparam logic [7:0] SUB_CFG_RD = 8'h05;
  localparam logic [7:0] SUB_TRIG_RD = 8'h06;
  localparam logic [7:0] SUB_CFG = 8'h08;
  localparam logic [7:0] SUB_TRIG = 8'h09;
  localparam logic [7:0] SUB_OUTC = 8'h11;
  localparam logic [7:0] SUB_OUTD = 8'h22;
  localparam logic [2:0] IDX_CFG_RD = 3'h0;
  localparam logic [2:0] IDX_TRIG_RD = 3'h1;
  localparam logic [2:0] IDX_CFG = 3'h2;
  localparam logic [2:0] IDX_TRIG = 3'h3;
  localparam logic [2:0] IDX_OUTC = 3'h4;
  localparam logic [2:0] IDX_OUTD = 3'h5;
  localparam logic [2:0] IDX_LAST = 3'h5;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // ======================================================
  // Field positions
  localparam int CFG_LOCK_REF_BIT = 0;
  localparam int CFG_RATIO_LSB = 2;
  localparam int CFG_RANGE_LSB = 6;
  localparam int TRIG_ACQ_BIT = 5;

  // ======================================================
  // Slave states, Gray along the usual path
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_SUB = 4'h2,
    ST_SUB_ACK = 4'h6,
    ST_WDATA = 4'h7,
    ST_WACK = 4'h5,
    ST_RDATA = 4'h4,
    ST_RACK = 4'hc
  } bca_state_t;

  // Returns {valid, index}
  function automatic logic [3:0] bca_sub_lookup(input logic [7:0] sub);
    logic [3:0] r;
    r = 4'h0;
    if (sub == SUB_CFG_RD) r = {1'b1, IDX_CFG_RD};
    else if (sub == SUB_TRIG_RD) r = {1'b1, IDX_TRIG_RD};
    else if (sub == SUB_CFG) r = {1'b1, IDX_CFG};
    else if (sub == SUB_TRIG) r = {1'b1, IDX_TRIG};
    else if (sub == SUB_OUTC) r = {1'b1, IDX_OUTC};
    else if (sub == SUB_OUTD) r = {1'b1, IDX_OUTD};
    return r;
  endfunction : bca_sub_lookup
endpackage : bca_pkg

//--- common/bca_burst_if.sv
/*
  Carrier between the control top and the preamble detector.
  Assumes both ends run on the same system clock.
*/
interface bca_burst_if;
  logic link_rise;
  logic link_bit;
  logic burst_reset;
  logic valid_n;
  modport det(input link_rise, input link_bit, input burst_reset, output valid_n);
  modport core(output link_rise, output link_bit, output burst_reset, input valid_n);
endinterface : bca_burst_if

//--- rtl/bca_burst_detect.sv
/*
  Preamble detector: counts alternating bits and flags valid data, active low.
  Assumes link edges and burst reset arrive already synchronised to i_clk.
*/
module bca_burst_detect
  import bca_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  bca_burst_if.det bif
);
  logic [3:0] run_reg, run_next;
  logic prev_reg, prev_next;
  logic valid_n_reg, valid_n_next;

  // ======================================================
  // Alternation counter
  always_comb begin
    run_next = run_reg;
    prev_next = prev_reg;
    valid_n_next = valid_n_reg;
    if (bif.burst_reset) begin
      run_next = 4'h0;
      valid_n_next = 1'b1;
    end else if (bif.link_rise && valid_n_reg) begin
      prev_next = bif.link_bit;
      if (run_reg == 4'h0 || bif.link_bit == prev_reg) run_next = 4'h1;
      else run_next = run_reg + 4'h1;
      if (run_reg != 4'h0 && bif.link_bit != prev_reg && run_reg == 4'(PRE_UI - 1)) begin
        valid_n_next = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      run_reg <= 4'h0;
      prev_reg <= 1'b0;
      valid_n_reg <= 1'b1;
    end else begin
      run_reg <= run_next;
      prev_reg <= prev_next;
      valid_n_reg <= valid_n_next;
    end
  end

  assign bif.valid_n = valid_n_reg;

  // ======================================================
  // Checks
  a_valid_at_twelve: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $fell(valid_n_reg) |-> $past(run_reg) == 4'(PRE_UI - 1) && $past(bif.link_rise))
    else $error("valid asserted before twelve alternating bits");
  a_valid_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (!valid_n_reg && !bif.burst_reset) |=> !valid_n_reg)
    else $error("valid dropped without burst reset");
  a_valid_clear: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    bif.burst_reset |=> valid_n_reg)
    else $error("valid not cleared by burst reset");
  c_valid_seen: cover property (@(posedge i_clk) disable iff (!i_rst_b) $fell(valid_n_reg));
endmodule : bca_burst_detect

//--- rtl/bca_cdr_ctrl.sv
/*
  Control top of the burst CDR: I2C slave, control registers, frequency acquisition
  sequencing, burst output gating and squelch.
  Assumes all pins are asynchronous to i_clk; the link clock is slow enough to sample.
*/
// Overview of operation
// - Writing trigger one then zero starts a roughly 10 ms frequency acquisition.
// - Alternating preamble is detected and phase acquired within 12 UI.
// - Data valid goes low 12 UI after alternating pattern starts.
// - Data valid stays low until burst reset, then returns high.
// - Squelch high forces recovered clock and data outputs to zero.
// - Bus address is 1, 0000, then two strap bits.
// - Last bit of first byte: one is read, zero is write.
// - Start is SDA falling while SCK high; eight bits follow MSB first.
// - Matching address is acknowledged on ninth pulse; otherwise stay idle.
// - Second byte is starting subaddress; six subaddresses exist.
// - Subaddress auto-increments after each data byte for reads and writes.
// - Start or stop anywhere returns the slave to idle or address phase.
// - Unknown subaddress gets no acknowledge and slave returns to idle.
// - Reads past last subaddress repeat last register until master not-acknowledges.
// - Two-bit range field selects reference band, default 10 to 25 MHz.
// - Four-bit ratio field sets lock target data rate over 2^n.
// - Writable control registers reset to all zeros.
module bca_cdr_ctrl
  import bca_pkg::*;
#(
  parameter int ACQ_CYCLES_P = ACQ_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe_b,
  input wire logic i_addr_strap2,
  input wire logic i_addr_strap1,
  input wire logic i_link_clk,
  input wire logic i_link_data,
  input wire logic i_burst_reset,
  input wire logic i_squelch,
  output logic o_clk_out,
  output logic o_data_out,
  output logic o_burst_data_valid_n,
  output logic o_lock_to_ref,
  output logic [1:0] o_ref_range,
  output logic [3:0] o_rate_ratio,
  output logic o_freq_locked,
  output logic o_acq_busy,
  output logic [7:0] o_out_ctrl_c,
  output logic [7:0] o_out_ctrl_d
);
  localparam int ACQ_W = $clog2(ACQ_CYCLES_P + 1);

  // ======================================================
  // Pin synchronisers
  logic [7:0] sy1_reg, sy2_reg;
  logic [2:0] dly_reg;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sy1_reg <= 8'hc0;
      sy2_reg <= 8'hc0;
      dly_reg <= 3'h6;
    end else begin
      sy1_reg <= {i_scl, i_sda, i_addr_strap2, i_addr_strap1, i_link_clk, i_link_data, i_burst_reset, i_squelch};
      sy2_reg <= sy1_reg;
      dly_reg <= {sy2_reg[7], sy2_reg[6], sy2_reg[3]};
    end
  end

  logic scl, sda, scl_d, sda_d, lclk, lclk_d, ldata, breset, squelch;
  logic [6:0] bus_device_address;
  assign scl = sy2_reg[7];
  assign sda = sy2_reg[6];
  assign lclk = sy2_reg[3];
  assign ldata = sy2_reg[2];
  assign breset = sy2_reg[1];
  assign squelch = sy2_reg[0];
  assign scl_d = dly_reg[2];
  assign sda_d = dly_reg[1];
  assign lclk_d = dly_reg[0];
  assign bus_device_address = {ADDR_HI_BITS, sy2_reg[5], sy2_reg[4]};

  logic start_cond, stop_cond, scl_rise, scl_fall;
  assign start_cond = scl && scl_d && sda_d && !sda;
  assign stop_cond = scl && scl_d && !sda_d && sda;
  assign scl_rise = scl && !scl_d;
  assign scl_fall = !scl && scl_d;

  // ======================================================
  // Control registers
  logic [7:0] cfg_reg, cfg_next, trig_reg, trig_next, outc_reg, outc_next, outd_reg, outd_next;
  logic arm_reg, arm_next, busy_reg, busy_next, locked_reg, locked_next;
  logic [ACQ_W-1:0] acq_cnt_reg, acq_cnt_next;
  logic acq_start;

  // ======================================================
  // I2C slave
  bca_state_t st_reg, st_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next, tx_reg, tx_next;
  logic pull_reg, pull_next, rw_reg, rw_next, wr_stb;
  logic [2:0] idx_reg, idx_next, idx_inc;
  logic [3:0] sub_hit;
  logic [7:0] rd_now, rd_inc;
  logic addr_match;

  function automatic logic [7:0] rd_byte(input logic [2:0] i);
    logic [7:0] r;
    r = 8'h00;
    if (i == IDX_CFG_RD) r = cfg_reg;
    else if (i == IDX_TRIG_RD) r = trig_reg;
    return r;
  endfunction : rd_byte

  assign addr_match = sh_reg[7:1] == bus_device_address;
  assign sub_hit = bca_sub_lookup(sh_reg);
  assign idx_inc = (idx_reg == IDX_LAST) ? idx_reg : idx_reg + 3'h1;
  assign rd_now = rd_byte(idx_reg);
  assign rd_inc = rd_byte(idx_inc);

  always_comb begin
    st_next = st_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    tx_next = tx_reg;
    pull_next = pull_reg;
    idx_next = idx_reg;
    rw_next = rw_reg;
    wr_stb = 1'b0;
    if (stop_cond) begin
      st_next = ST_IDLE;
      pull_next = 1'b0;
    end else if (start_cond) begin
      st_next = ST_ADDR;
      bit_next = 4'h0;
      pull_next = 1'b0;
    end else if (scl_rise) begin
      case (st_reg)
        ST_ADDR, ST_SUB, ST_WDATA: begin
          sh_next = {sh_reg[6:0], sda};
          bit_next = bit_reg + 4'h1;
        end
        ST_RDATA: bit_next = bit_reg + 4'h1;
        ST_RACK: if (sda) st_next = ST_IDLE;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (st_reg)
        ST_ADDR: if (bit_reg == BITS_PER_BYTE) begin
          if (addr_match) begin
            st_next = ST_ADDR_ACK;
            pull_next = 1'b1;
            rw_next = sh_reg[0];
          end else begin
            st_next = ST_IDLE;
          end
        end
        ST_ADDR_ACK: begin
          bit_next = 4'h0;
          if (rw_reg) begin
            st_next = ST_RDATA;
            pull_next = ~rd_now[7];
            tx_next = {rd_now[6:0], 1'b0};
          end else begin
            st_next = ST_SUB;
            pull_next = 1'b0;
          end
        end
        ST_SUB: if (bit_reg == BITS_PER_BYTE) begin
          if (sub_hit[3]) begin
            st_next = ST_SUB_ACK;
            pull_next = 1'b1;
            idx_next = sub_hit[2:0];
          end else begin
            st_next = ST_IDLE;
          end
        end
        ST_SUB_ACK, ST_WACK: begin
          st_next = ST_WDATA;
          pull_next = 1'b0;
          bit_next = 4'h0;
        end
        ST_WDATA: if (bit_reg == BITS_PER_BYTE) begin
          st_next = ST_WACK;
          pull_next = 1'b1;
          wr_stb = 1'b1;
          idx_next = idx_inc;
        end
        ST_RDATA: begin
          if (bit_reg == BITS_PER_BYTE) begin
            st_next = ST_RACK;
            pull_next = 1'b0;
          end else begin
            pull_next = ~tx_reg[7];
            tx_next = {tx_reg[6:0], 1'b0};
          end
        end
        ST_RACK: begin
          st_next = ST_RDATA;
          bit_next = 4'h0;
          idx_next = idx_inc;
          pull_next = ~rd_inc[7];
          tx_next = {rd_inc[6:0], 1'b0};
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg <= ST_IDLE;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      tx_reg <= 8'h00;
      pull_reg <= 1'b0;
      idx_reg <= IDX_CFG_RD;
      rw_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      tx_reg <= tx_next;
      pull_reg <= pull_next;
      idx_reg <= idx_next;
      rw_reg <= rw_next;
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe_b = ~pull_reg;

  // ======================================================
  // Register writes and acquisition sequencing
  // Arm on a written one, fire on the following zero if not busy; a zero alone is a no-op.
  always_comb begin
    cfg_next = cfg_reg;
    trig_next = trig_reg;
    outc_next = outc_reg;
    outd_next = outd_reg;
    arm_next = arm_reg;
    acq_start = 1'b0;
    if (wr_stb) begin
      if (idx_reg == IDX_CFG) cfg_next = sh_reg;
      else if (idx_reg == IDX_OUTC) outc_next = sh_reg;
      else if (idx_reg == IDX_OUTD) outd_next = sh_reg;
      else if (idx_reg == IDX_TRIG) begin
        trig_next = sh_reg;
        if (sh_reg[TRIG_ACQ_BIT]) begin
          arm_next = 1'b1;
        end else begin
          arm_next = 1'b0;
          acq_start = arm_reg && !busy_reg;
        end
      end
    end
  end

  always_comb begin
    busy_next = busy_reg;
    locked_next = locked_reg;
    acq_cnt_next = acq_cnt_reg;
    if (acq_start) begin
      busy_next = 1'b1;
      locked_next = 1'b0;
      acq_cnt_next = '0;
    end else if (busy_reg) begin
      if (acq_cnt_reg == ACQ_W'(ACQ_CYCLES_P - 1)) begin
        busy_next = 1'b0;
        locked_next = 1'b1;
      end else begin
        acq_cnt_next = acq_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_reg <= CTRL_RST;
      trig_reg <= CTRL_RST;
      outc_reg <= CTRL_RST;
      outd_reg <= CTRL_RST;
      arm_reg <= 1'b0;
      busy_reg <= 1'b0;
      locked_reg <= 1'b0;
      acq_cnt_reg <= '0;
    end else begin
      cfg_reg <= cfg_next;
      trig_reg <= trig_next;
      outc_reg <= outc_next;
      outd_reg <= outd_next;
      arm_reg <= arm_next;
      busy_reg <= busy_next;
      locked_reg <= locked_next;
      acq_cnt_reg <= acq_cnt_next;
    end
  end

  assign o_lock_to_ref = cfg_reg[CFG_LOCK_REF_BIT];
  assign o_ref_range = cfg_reg[CFG_RANGE_LSB+:2];
  assign o_rate_ratio = cfg_reg[CFG_RATIO_LSB+:4];
  assign o_freq_locked = locked_reg;
  assign o_acq_busy = busy_reg;
  assign o_out_ctrl_c = outc_reg;
  assign o_out_ctrl_d = outd_reg;

  // ======================================================
  // Burst path and squelch
  logic clk_out_reg, clk_out_next, dout_reg, dout_next;
  bca_burst_if bif();
  assign bif.link_rise = lclk && !lclk_d;
  assign bif.link_bit = ldata;
  assign bif.burst_reset = breset;

  bca_burst_detect u_detect (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .bif(bif)
  );

  always_comb begin
    clk_out_next = squelch ? 1'b0 : lclk;
    dout_next = dout_reg;
    if (squelch) dout_next = 1'b0;
    else if (bif.link_rise) dout_next = ldata;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      clk_out_reg <= 1'b0;
      dout_reg <= 1'b0;
    end else begin
      clk_out_reg <= clk_out_next;
      dout_reg <= dout_next;
    end
  end

  assign o_clk_out = clk_out_reg;
  assign o_data_out = dout_reg;
  assign o_burst_data_valid_n = bif.valid_n;

  // ======================================================
  // Checks
  a_squelch_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    squelch |=> (!o_clk_out && !o_data_out))
    else $error("outputs not zero under squelch");
  a_start_addr: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (start_cond && !stop_cond) |=> (st_reg == ST_ADDR && bit_reg == 4'h0))
    else $error("start did not open address phase");
  a_stop_idle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    stop_cond |=> (st_reg == ST_IDLE && !pull_reg))
    else $error("stop did not return to idle");
  a_addr_ack: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (st_reg == ST_ADDR && scl_fall && !start_cond && !stop_cond && bit_reg == BITS_PER_BYTE)
    |=> (pull_reg == $past(addr_match)) && (st_reg == ($past(addr_match) ? ST_ADDR_ACK : ST_IDLE)))
    else $error("address acknowledge wrong");
  a_read_dir: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (st_reg == ST_ADDR_ACK && scl_fall && !start_cond && !stop_cond)
    |=> (st_reg == ($past(rw_reg) ? ST_RDATA : ST_SUB)))
    else $error("direction bit not honoured");
  a_bad_sub: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (st_reg == ST_SUB && scl_fall && !start_cond && !stop_cond && bit_reg == BITS_PER_BYTE && !sub_hit[3])
    |=> (st_reg == ST_IDLE && !pull_reg))
    else $error("invalid subaddress acknowledged");
  a_auto_inc: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (wr_stb && idx_reg != IDX_LAST) |=> idx_reg == $past(idx_reg) + 3'h1)
    else $error("subaddress did not advance");
  a_read_sat: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (st_reg == ST_RACK && idx_reg == IDX_LAST && scl_fall && !start_cond && !stop_cond)
    |=> idx_reg == IDX_LAST)
    else $error("read ran past last subaddress");
  a_acq_begin: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    acq_start |=> (busy_reg && !locked_reg && acq_cnt_reg == '0) ##1 (busy_reg && !locked_reg && acq_cnt_reg == ACQ_W'(1)))
    else $error("acquisition did not start");
  a_trig_ignore: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (wr_stb && idx_reg == IDX_TRIG && !sh_reg[TRIG_ACQ_BIT] && (!arm_reg || busy_reg))
    |=> (busy_reg == $past(busy_reg) && locked_reg == $past(locked_reg)))
    else $error("incomplete trigger disturbed acquisition");
  a_reg_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (wr_stb && idx_reg == IDX_CFG) |=> o_ref_range == $past(sh_reg[7:6]))
    else $error("range field not written");
  c_write_byte: cover property (@(posedge i_clk) disable iff (!i_rst_b) wr_stb);
  c_read_ack: cover property (@(posedge i_clk) disable iff (!i_rst_b) st_reg == ST_RACK && scl_fall);
  c_acq_done: cover property (@(posedge i_clk) disable iff (!i_rst_b) $rose(locked_reg));
endmodule : bca_cdr_ctrl

//--- bench/bca_i2c_host.sv
/*
  Behavioural I2C host master that drives the control block's serial port.
  Assumes the bench resolves SDA as an open-drain wire with a pull-up.
*/
module bca_i2c_host (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  // ======================================
  // Bus phases
  // Quarter period kept long, well above the slave's sync delay
  localparam int QTR = 10;
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end
  task automatic q();
    repeat (QTR) @(posedge i_clk);
    #1;
  endtask : q
  // Also serves as repeated start
  task automatic start();
    o_sda_pull = 1'b0;
    q();
    o_scl = 1'b1;
    q();
    o_sda_pull = 1'b1;
    q();
    o_scl = 1'b0;
    q();
  endtask : start
  task automatic stop();
    o_sda_pull = 1'b1;
    q();
    o_scl = 1'b1;
    q();
    o_sda_pull = 1'b0;
    q();
  endtask : stop
  task automatic put_bit(input logic b, output logic r);
    o_sda_pull = ~b;
    q();
    o_scl = 1'b1;
    q();
    r = i_sda;
    q();
    o_scl = 1'b0;
    q();
  endtask : put_bit
  // Byte MSB first, then ninth pulse; ack_n high leaves SDA released
  task automatic xfer(input logic [7:0] d, input logic ack_n, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i], r[i]);
    put_bit(ack_n, a);
    ack = ~a;
  endtask : xfer
endmodule : bca_i2c_host

//--- bench/test_burst_cdr_i2c_acquisition_control.sv
/*
  Self-checking bench for bca_cdr_ctrl: host model on I2C, link driven by the bench.
  Assumes bca_pkg, bca_burst_if, the design and bca_i2c_host are compiled first.
*/
module test_burst_cdr_i2c_acquisition_control
  import bca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ======================================
  // Signals and instances
  localparam int ACQ = 2000;
  localparam logic [7:0] SUBS [6] = '{SUB_CFG_RD, SUB_TRIG_RD, SUB_CFG, SUB_TRIG, SUB_OUTC, SUB_OUTD};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic s2 = 1'b0;
  logic s1 = 1'b0;
  logic lclk = 1'b0;
  logic ldat = 1'b0;
  logic brst = 1'b0;
  logic sq = 1'b0;
  logic scl, pull, oe_b, sda_o, ck_o, d_o, vn, lref, locked, busy;
  logic [1:0] rng;
  logic [3:0] ratio;
  logic [7:0] oc, od;
  logic [7:0] wmem [6] = '{default: 8'h00};
  int bad_count = 0;
  int cmp_count = 0;
  int seed = 52;
  int busy_cyc = 0;
  wire sda = ~(pull | (~oe_b & ~sda_o));
  always #10 clk = ~clk;
  always @(posedge clk) if (busy === 1'b1) busy_cyc <= busy_cyc + 1;
  bca_cdr_ctrl #(.ACQ_CYCLES_P(ACQ)) dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_o), .o_sda_oe_b(oe_b),
    .i_addr_strap2(s2), .i_addr_strap1(s1), .i_link_clk(lclk), .i_link_data(ldat),
    .i_burst_reset(brst), .i_squelch(sq), .o_clk_out(ck_o), .o_data_out(d_o),
    .o_burst_data_valid_n(vn), .o_lock_to_ref(lref), .o_ref_range(rng), .o_rate_ratio(ratio),
    .o_freq_locked(locked), .o_acq_busy(busy), .o_out_ctrl_c(oc), .o_out_ctrl_d(od)
  );
  bca_i2c_host host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));
  // ======================================
  // Checks and model
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic chk_outs();
    chk("lock_ref", 8'(wmem[2][0]), 8'(lref));
    chk("range", 8'(wmem[2][7:6]), 8'(rng));
    chk("ratio", 8'(wmem[2][5:2]), 8'(ratio));
    chk("ctrl_c", wmem[4], oc);
    chk("ctrl_d", wmem[5], od);
  endtask : chk_outs
  function automatic logic [7:0] adr(input logic rw);
    return {1'b1, 4'h0, s2, s1, rw};
  endfunction : adr
  // Readback places mirror the written config and trigger bytes only
  function automatic logic [7:0] mread(input int i);
    return (i == 0) ? wmem[2] : (i == 1) ? wmem[3] : 8'h00;
  endfunction : mread
  task automatic send(input logic [7:0] d, input logic exp);
    logic [7:0] r;
    logic a;
    host.xfer(d, 1'b1, r, a);
    chk("ack", 8'(exp), 8'(a));
  endtask : send
  task automatic head(input logic [7:0] sub, input logic ok);
    host.start();
    send(adr(1'b0), 1'b1);
    send(sub, ok);
  endtask : head
  task automatic wr(input int i0, input logic [7:0] q [$]);
    int i;
    i = i0;
    head(SUBS[i0], 1'b1);
    foreach (q[k]) begin
      send(q[k], 1'b1);
      if (i > 1) wmem[i] = q[k];
      i = (i < 5) ? i + 1 : 5;
    end
    host.stop();
    repeat (4) @(posedge clk);
    #1;
    chk_outs();
  endtask : wr
  task automatic rd(input int i0, input int n);
    logic [7:0] r;
    logic a;
    int i;
    i = i0;
    head(SUBS[i0], 1'b1);
    host.start();
    send(adr(1'b1), 1'b1);
    for (int k = 0; k < n; k++) begin
      host.xfer(8'hff, k == n - 1, r, a);
      chk("rdata", mread(i), r);
      i = (i < 5) ? i + 1 : 5;
    end
    host.stop();
  endtask : rd
  // One link bit, 160 ns; the link clock only runs inside frames
  task automatic lbit(input logic b);
    ldat = b;
    repeat (2) @(posedge clk);
    #1 lclk = 1'b1;
    repeat (4) @(posedge clk);
    #1 lclk = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : lbit
  // ======================================
  // Main sequence
  initial begin
    logic [7:0] q [$];
    logic [7:0] c;
    repeat (6) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk_outs();
    chk("valid_n", 8'h01, 8'(vn));
    chk("acq", 8'h00, 8'({busy, locked}));
    for (int s = 0; s < 4; s++) begin
      {s2, s1} = s[1:0];
      repeat (4) @(posedge clk);
      #1;
      host.start();
      send(adr(1'b0) ^ 8'h20, 1'b0);
      host.stop();
      c = {s[1:0], 4'($unsigned($random(seed)) % 9), 2'b01};
      q = {c, 8'h00, 8'($random(seed)), 8'($random(seed))};
      wr(2, q);
      chk("busy", 8'h00, 8'(busy));
      rd(0, 8);
    end
    head(8'h07, 1'b0);
    host.stop();
    head(SUBS[2], 1'b1);
    for (int k = 0; k < 4; k++) host.put_bit(1'b1, c[k]);
    host.stop();
    chk_outs();
    q = {8'h5a, 8'ha5, 8'h3c};
    wr(4, q);
    q = {8'h20};
    wr(3, q);
    q = {8'h00};
    wr(3, q);
    chk("acq", 8'h02, 8'({busy, locked}));
    wr(3, q);
    chk("acq", 8'h02, 8'({busy, locked}));
    for (int k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge clk);
    #1;
    chk("acq", 8'h01, 8'({busy, locked}));
    if (busy !== 1'b0) end_sim();
    chk("acq_len", 8'h01, 8'(busy_cyc >= ACQ - 1 && busy_cyc <= ACQ + 1));
    brst = 1'b1;
    for (int k = 0; k < 16; k++) lbit(1'($random(seed)));
    chk("valid_n", 8'h01, 8'(vn));
    brst = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    for (int k = 1; k <= 14; k++) begin
      lbit(k[0]);
      chk("valid_n", 8'(k < 12), 8'(vn));
      chk("data_out", 8'(k[0]), 8'(d_o));
      chk("clk_out", 8'h01, 8'(ck_o));
    end
    sq = 1'b1;
    fork
      for (int k = 0; k < 6; k++) lbit(1'b1);
      begin
        repeat (4) @(posedge clk);
        for (int k = 0; k < 40; k++) begin
          @(posedge clk);
          #1;
          chk("squelch", 8'h00, 8'({ck_o, d_o}));
        end
      end
    join
    chk("valid_n", 8'h00, 8'(vn));
    sq = 1'b0;
    brst = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk("valid_n", 8'h01, 8'(vn));
    end_sim();
  end
endmodule : test_burst_cdr_i2c_acquisition_control
